// *** inc/acrc_consts.svh ***
// Purpose: named constants of the calibration and reset controller
// Assumes: included by bare name from the package, the checker and the testbench
// Notes: byte addresses on a 32-bit wishbone bus
`ifndef ACRC_CONSTS_SVH
`define ACRC_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ACRC_A_STATUS 8'h00
`define ACRC_A_MODE 8'h04
`define ACRC_A_DATA 8'h08
`define ACRC_A_OFS0 8'h10
`define ACRC_A_GAIN0 8'h20

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define ACRC_F_MODE 2:0
`define ACRC_F_CHOP 3
`define ACRC_F_AC 4
`define ACRC_F_CHAN 6:5
`define ACRC_F_FAST 7
`define ACRC_F_SKIP 8
`define ACRC_MODE_W 9

// ----------------------------------------
// status register fields
// ----------------------------------------
`define ACRC_S_READY 0
`define ACRC_S_SETTLED 1
`define ACRC_S_MODE 4:2
`define ACRC_S_PD 5

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define ACRC_M_IDLE 3'h0
`define ACRC_M_CONT 3'h1
`define ACRC_M_SINGLE 3'h2
`define ACRC_M_STBY 3'h3
`define ACRC_M_IZS 3'h4
`define ACRC_M_IFS 3'h5
`define ACRC_M_SZS 3'h6
`define ACRC_M_SFS 3'h7

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define ACRC_MODE_RST 9'h008
`define ACRC_OFS_RST 24'h800000
`define ACRC_GAIN_RST 24'h593cea
`define ACRC_ZS_CHOP 6'h16
`define ACRC_ZS_NOCHOP 6'h18
`define ACRC_FS_CHOP 6'h2c
`define ACRC_FS_NOCHOP 6'h30
`define ACRC_ONES_RESET 6'h20

`endif

// *** inc/acrc_pkg.sv ***
// Purpose: types of the calibration and reset controller
// Assumes: constants come from acrc_consts.svh
// Notes: none
package acrc_pkg;
`include "acrc_consts.svh"

   // controller sequencing states
   typedef enum logic [1:0] {ACRC_IDLE, ACRC_CAL} acrc_state_t;

   // calibration coefficient word
   typedef logic [23:0] acrc_word_t;

endpackage : acrc_pkg

// *** sim/acrc_ctrl_sva.sv ***
// Purpose: port checks of the calibration and reset controller
// Assumes: bound to every acrc_ctrl instance
// Notes: chop bit and word count taken from mode writes
`timescale 1ns/10ps
`include "acrc_consts.svh"
module acrc_ctrl_chk
   import acrc_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic [7:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [3:0] wb_sel_i, // byte enables
   input wire logic wb_we_i, // write
   input wire logic wb_ack_o, // ack
   input wire logic reset_pin, // reset pin
   input wire logic standby_pin, // standby pin
   input wire logic word_done, // word pulse
   input wire logic rdy_pin, // busy
   input wire logic filter_reset, // filter reset
   input wire logic analog_pd, // power down
   input wire logic [2:0] mode_out, // mode
   input wire logic fast_eff, // quick settle
   input wire logic skip_eff, // bypass
   input wire logic excite_ac, // ac drive
   input wire logic [1:0] cal_input, // cal source
   input wire logic bridge_drive_phase, // excitation phase
   input wire logic serial_reset // serial reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic mw;
   logic chop_q;
   logic [5:0] cnt_q;
   logic [5:0] n_exp;
   // accepted mode write and expected length
   assign mw = wb_ack_o && wb_we_i && wb_adr_i == `ACRC_A_MODE && wb_sel_i[0];
   assign n_exp = (mode_out == `ACRC_M_IFS) ? (chop_q ? `ACRC_FS_CHOP : `ACRC_FS_NOCHOP) :
      (chop_q ? `ACRC_ZS_CHOP : `ACRC_ZS_NOCHOP);
   // words seen since the last mode write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chop_q <= 1'b0;
         cnt_q <= 6'h00;
      end else if (mw) begin
         chop_q <= wb_dat_i[`ACRC_F_CHOP];
         cnt_q <= 6'h00;
      end else if (word_done && !filter_reset && cnt_q != 6'h3f) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
   por_state_a: assert property ($fell(rst) |-> rdy_pin && analog_pd && mode_out == 3'h0)
      else $error("state after power-on wrong");
   cal_start_a: assert property (mw && wb_dat_i[2] |=> rdy_pin)
      else $error("ready not raised by calibration");
   cal_end_a: assert property ($fell(rdy_pin) && $past(mode_out[2]) |-> mode_out == 3'h0)
      else $error("mode not idle at calibration end");
   full_filter_a: assert property (mode_out[2] && $past(mode_out[2]) |-> !fast_eff && !skip_eff)
      else $error("filter shortcut during calibration");
   int_dc_a: assert property (mode_out[2:1] == 2'b10 && $stable(mode_out) |-> !excite_ac)
      else $error("ac drive in internal calibration");
   cal_src_a: assert property (mode_out[2] && $stable(mode_out) |->
      cal_input == (mode_out[1] ? 2'd0 : (mode_out[0] ? 2'd2 : 2'd1)))
      else $error("calibration input wrong");
   cal_len_a: assert property ($fell(rdy_pin) && $past(mode_out[2]) |-> cnt_q == $past(n_exp))
      else $error("calibration length wrong");
   stby_set_a: assert property (standby_pin [*4] |-> analog_pd && rdy_pin && filter_reset)
      else $error("standby effects missing");
   rst_pin_a: assert property (reset_pin [*4] |-> mode_out == 3'h0 && rdy_pin && serial_reset &&
      $stable(analog_pd))
      else $error("reset pin effects wrong");
   dc_phase_a: assert property (!excite_ac |=> !bridge_drive_phase)
      else $error("excitation phase moves under dc drive");
   cover property (excite_ac && bridge_drive_phase);
   cover property ($fell(rdy_pin) && $past(mode_out) == `ACRC_M_IFS);
   cover property (standby_pin [*4]);
   cover property (reset_pin [*4]);
endmodule : acrc_ctrl_chk
bind acrc_ctrl acrc_ctrl_chk u_acrc_ctrl_chk (.clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i,
   .wb_we_i, .wb_ack_o, .reset_pin, .standby_pin, .word_done, .rdy_pin, .filter_reset,
   .analog_pd, .mode_out, .fast_eff, .skip_eff, .excite_ac, .cal_input, .bridge_drive_phase,
   .serial_reset);

// *** sim/acrc_filt_model.sv ***
// Purpose: filter side model feeding output words
// Assumes: one word every PER clocks after a filter reset
// Notes: stall holds words back, as a slow filter would
`timescale 1ns/10ps
module acrc_filt_model #(
   parameter int PER = 12 // clocks per output word
) (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic filter_reset, // restart request
   input wire logic stall, // hold back words
   input wire logic [23:0] coef_in, // next coefficient
   output logic word_done, // word pulse
   output logic [23:0] filt_word, // word value
   output logic [23:0] cal_result // coefficient
);
   logic [7:0] cnt_q;
   assign cal_result = coef_in;
   // word timer, restarted by every filter reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
         word_done <= 1'b0;
         filt_word <= 24'h0a0b0c;
      end else if (filter_reset) begin
         cnt_q <= 8'h00;
         word_done <= 1'b0;
      end else if (stall || cnt_q != 8'(PER - 1)) begin
         cnt_q <= stall ? cnt_q : cnt_q + 8'h01;
         word_done <= 1'b0;
      end else begin
         cnt_q <= 8'h00;
         word_done <= 1'b1;
         filt_word <= filt_word + 24'h010203;
      end
   end
endmodule : acrc_filt_model

// *** sim/tb.sv ***
// Purpose: register level test of the calibration and reset controller
// Assumes: classic wishbone, ack one cycle after request
// Notes: pd bit masked where its value is left open
`timescale 1ns/10ps
`include "acrc_consts.svh"
module tb;
   import acrc_pkg::*;
   logic clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [3:0] wb_sel_i;
   logic reset_pin, standby_pin, restart_pin, sclk_pin, sdin_pin, word_done, stall;
   logic rdy_pin, filter_reset, serial_reset, analog_pd, fast_eff, skip_eff;
   logic excite_ac, bridge_drive_phase;
   logic [2:0] mode_out;
   logic [1:0] cal_input;
   logic [23:0] filt_word, cal_result, coef;
   acrc_word_t ofs_out, gain_out;
   int fail_count = 0;
   int comparisons = 0;
   logic [2:0] codes [4] = '{3'h5, 3'h4, 3'h6, 3'h7}; // range lies outside block
   acrc_ctrl #(.EXC_DIV(4)) u_acrc_ctrl (.clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .reset_pin, .standby_pin,
      .restart_pin, .sclk_pin, .sdin_pin, .word_done, .filt_word, .cal_result, .rdy_pin,
      .filter_reset, .serial_reset, .analog_pd, .mode_out, .fast_eff, .skip_eff, .excite_ac,
      .bridge_drive_phase, .cal_input, .ofs_out, .gain_out);
   acrc_filt_model u_acrc_filt_model (.clk, .rst, .filter_reset, .stall, .coef_in(coef),
      .word_done, .filt_word, .cal_result);
   task automatic summarize();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle, request held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // ack and read data are taken at the rising edge itself
      do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) begin fail_count++; summarize(); end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask : rd
   // wait for ready low, counting words and noting ac drive
   task automatic run_cal(output int nw, output logic ac);
      int n;
      nw = 0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n == 8) ac = excite_ac;
         if (word_done === 1'b1) nw++;
      end while (rdy_pin !== 1'b0 && n < 4000);
      if (n >= 4000) begin fail_count++; summarize(); end
      @(posedge clk);
   endtask : run_cal
   // r high pulses the reset pin, low the filter restart pin
   task automatic pin_pulse(input logic r);
      if (r) begin
         reset_pin <= 1'b1;
      end else begin
         restart_pin <= 1'b1;
      end
      repeat (5) @(posedge clk);
      reset_pin <= 1'b0;
      restart_pin <= 1'b0;
      repeat (5) @(posedge clk);
   endtask : pin_pulse
   task automatic sbits(input int k, input logic b);
      repeat (k) begin
         sdin_pin <= b;
         repeat (3) @(posedge clk);
         sclk_pin <= 1'b1;
         repeat (3) @(posedge clk);
         sclk_pin <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask : sbits
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      int nw;
      logic ac, pdb;
      logic [2:0] c;
      logic [1:0] ch;
      {rst, wb_we_i, wb_cyc_i, wb_stb_i, reset_pin, standby_pin} = 6'h20;
      {restart_pin, sclk_pin, sdin_pin, stall} = 4'h0;
      {wb_adr_i, wb_dat_i, wb_sel_i, coef} = '0;
      wb_sel_i = 4'hf;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`ACRC_A_STATUS, 32'h3f, 32'h23);
      rd(`ACRC_A_MODE, 32'hffffffff, 32'h008);
      rd(`ACRC_A_OFS0 + 8'h04, 32'hffffffff, 32'h800000);
      rd(`ACRC_A_GAIN0 + 8'h08, 32'hffffffff, 32'h593cea);
      wr(8'h3c, 32'hffffffff);
      rd(8'h3c, 32'hffffffff, 32'h0);
      // internal full-scale before internal zero-scale, system zero before system full
      for (int i = 0; i < 8; i++) begin
         c = codes[i % 4];
         ch = 2'(i % 3);
         coef <= 24'h100000 + 24'(i);
         wr(`ACRC_A_MODE, {23'h0, 2'b11, ch, 1'b1, i < 4, c});
         rd(`ACRC_A_STATUS, 32'h1f, {c, 2'b11});
         run_cal(nw, ac);
         chk(nw, c == 3'h5 ? (i < 4 ? 44 : 48) : (i < 4 ? 22 : 24));
         chk(ac, c[1]);
         rd(`ACRC_A_STATUS, 32'h1f, 32'h02);
         rd(`ACRC_A_MODE, 32'hffffffff, {23'h0, 2'b11, ch, 1'b1, i < 4, 3'h0});
         rd((c[0] ? `ACRC_A_GAIN0 : `ACRC_A_OFS0) + {4'h0, ch, 2'b00}, 32'hffffffff,
            {8'h0, coef});
         chk(c[0] ? gain_out : ofs_out, coef);
      end
      wr(`ACRC_A_MODE, 32'h009);
      run_cal(nw, ac);
      stall <= 1'b1;
      rd(`ACRC_A_STATUS, 32'h1f, 32'h04);
      rd(`ACRC_A_DATA, 32'hffffffff, {8'h0, filt_word});
      rd(`ACRC_A_STATUS, 32'h1f, 32'h05);
      pdb = analog_pd;
      pin_pulse(1'b0);
      rd(`ACRC_A_STATUS, 32'h3f, {2'b00, pdb, 5'h07});
      standby_pin <= 1'b1;
      repeat (5) @(posedge clk);
      rd(`ACRC_A_STATUS, 32'h3f, 32'h27);
      rd(`ACRC_A_MODE, 32'hffffffff, 32'h009);
      standby_pin <= 1'b0;
      stall <= 1'b0;
      wr(`ACRC_A_MODE, 32'h00b);
      rd(`ACRC_A_STATUS, 32'h3f, 32'h2f);
      wr(`ACRC_A_MODE, 32'h008);
      rd(`ACRC_A_STATUS, 32'h1f, 32'h03);
      wr(`ACRC_A_OFS0, 32'h123456);
      wr(`ACRC_A_MODE, 32'h029);
      pdb = analog_pd;
      pin_pulse(1'b1);
      rd(`ACRC_A_OFS0, 32'hffffffff, 32'h800000);
      chk(analog_pd, pdb);
      wr(`ACRC_A_MODE, 32'h029);
      wr(`ACRC_A_GAIN0 + 8'h04, 32'h000abc);
      sbits(31, 1'b1);
      sbits(1, 1'b0);
      rd(`ACRC_A_MODE, 32'hffffffff, 32'h029);
      sbits(32, 1'b1);
      rd(`ACRC_A_MODE, 32'hffffffff, 32'h008);
      rd(`ACRC_A_GAIN0 + 8'h04, 32'hffffffff, 32'h593cea);
      rd(`ACRC_A_STATUS, 32'h1f, 32'h03);
      summarize();
   end
endmodule : tb

// *** verilog/acrc_ctrl.sv ***
// Purpose: calibration sequencer and reset event control of a bridge adc
// Assumes: word_done and cal_result come from filter logic on clk
// Notes: pins pass two flops; registers on classic wishbone
// Functional notes
// - starting a calibration raises ready pin and bit; they fall when it ends
// - mode field is back to idle when ready falls after calibration
// - quick-settle and filter-bypass act as cleared at their outputs during calibration
// - mode 100: internal zero-scale, 22/24 words, updates channel offset
// - internal calibrations ignore alternating excitation and use dc
// - mode 101: internal full-scale, 44/48 words, updates channel gain
// - mode 110: system zero-scale, 22/24 words, updates channel offset
// - mode 111: system full-scale, 22/24 words, updates channel gain
// - system calibrations keep alternating excitation when it is selected
// - power-on reset: defaults, idle, filter reset, analog down, serial reset
// - reset pin: like power-on but analog power left alone
// - standby pin: filter reset, analog down, flags set, registers kept
// - mode 011 write: filter reset, analog down, flags set
// - filter restart pin: filter reset, flags set, running calibration dropped
// - mode 000 write: load mode, filter reset and flags set
// - conversion or calibration write: load mode, filter reset, flags set
// - 32 ones on serial input act like the reset pin
// - data register read sets ready only
// - offset registers 24 bits, reset 800000, subtracted before gain
// - gain registers reset 593cea, scale the offset-corrected result
`timescale 1ns/10ps

module acrc_ctrl
   import acrc_pkg::*;
#(
   parameter int NCH = 3, // calibration register pairs
   parameter int EXC_DIV = 64 // clk cycles per excitation half period
) (
   input wire logic clk, // 125 MHz clock
   input wire logic rst, // power-on reset, async, high
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [3:0] wb_sel_i, // byte enables
   input wire logic wb_we_i, // write
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic reset_pin, // reset pin, high
   input wire logic standby_pin, // standby pin, high
   input wire logic restart_pin, // filter restart pin, high
   input wire logic sclk_pin, // serial clock pin
   input wire logic sdin_pin, // serial data in pin
   input wire logic word_done, // filter output word pulse
   input wire logic [23:0] filt_word, // filter output word
   input wire logic [23:0] cal_result, // coefficient from cal arithmetic
   output logic rdy_pin, // ready pin, high while busy
   output logic filter_reset, // filter reset pulse
   output logic serial_reset, // serial interface reset pulse
   output logic analog_pd, // analog power down
   output logic [2:0] mode_out, // operating mode field
   output logic fast_eff, // effective quick-settle
   output logic skip_eff, // effective filter bypass
   output logic excite_ac, // alternating excitation active
   output logic bridge_drive_phase, // excitation phase
   output logic [1:0] cal_input, // 0 ext, 1 short, 2 int full-scale
   output acrc_word_t ofs_out, // offset of selected channel
   output acrc_word_t gain_out // gain of selected channel
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   // output words a calibration lasts
   function automatic logic [5:0] cal_words(input logic [2:0] m, input logic chop);
      if (m == `ACRC_M_IFS) begin
         return chop ? `ACRC_FS_CHOP : `ACRC_FS_NOCHOP;
      end
      return chop ? `ACRC_ZS_CHOP : `ACRC_ZS_NOCHOP;
   endfunction : cal_words

   // map channels beyond existing pairs to channel 0
   function automatic logic [1:0] chan_idx(input logic [1:0] c);
      return (int'(c) < NCH) ? c : 2'h0;
   endfunction : chan_idx

   // ----------------------------------------
   // pin synchronisers and edges
   // ----------------------------------------
   logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
         pin_s3_q <= 5'h00;
      end else begin
         pin_s1_q <= {sdin_pin, sclk_pin, restart_pin, standby_pin, reset_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   wire logic pin_reset = pin_s2_q[0];
   wire logic pin_stby = pin_s2_q[1];
   wire logic rise_reset = pin_s2_q[0] & ~pin_s3_q[0];
   wire logic rise_stby = pin_s2_q[1] & ~pin_s3_q[1];
   wire logic rise_restart = pin_s2_q[2] & ~pin_s3_q[2];
   wire logic sclk_rise = pin_s2_q[3] & ~pin_s3_q[3];
   wire logic sdin_s = pin_s2_q[4];

   // ----------------------------------------
   // serial ones watcher
   // ----------------------------------------
   logic [5:0] ones_q, ones_d;
   wire logic ones_hit = sclk_rise & sdin_s & (ones_q == `ACRC_ONES_RESET - 6'h01);
   // count consecutive ones clocked in
   assign ones_d = !sclk_rise ? ones_q : (!sdin_s || ones_hit) ? 6'h00 : ones_q + 6'h01;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ones_q <= 6'h00;
      end else begin
         ones_q <= ones_d;
      end
   end

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   logic ack_q;
   logic [31:0] rdat_q;
   wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire logic wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
   wire logic rd_take = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_q;
   wire logic hit_mode = wb_adr_i == `ACRC_A_MODE;
   wire logic hit_data = wb_adr_i == `ACRC_A_DATA;
   wire logic [1:0] cal_idx = wb_adr_i[3:2];
   wire logic hit_ofs = (wb_adr_i[7:4] == 4'(`ACRC_A_OFS0 >> 4)) && int'(cal_idx) < NCH;
   wire logic hit_gain = (wb_adr_i[7:4] == 4'(`ACRC_A_GAIN0 >> 4)) && int'(cal_idx) < NCH;
   wire logic mode_wr = wr_take & hit_mode & wb_sel_i[0];

   // ----------------------------------------
   // control state
   // ----------------------------------------
   acrc_state_t state_q;
   logic [`ACRC_MODE_W-1:0] mode_q;
   logic ready_q, settled_q, pd_q, frst_q, srst_q;
   logic [5:0] wcnt_q;
   acrc_word_t data_q;
   acrc_word_t ofs_q [NCH];
   acrc_word_t gain_q [NCH];

   // effective values of mode register fields
   wire logic [2:0] mcode = mode_q[`ACRC_F_MODE];
   wire logic [1:0] chan = chan_idx(mode_q[`ACRC_F_CHAN]);
   wire logic cal_on = state_q == ACRC_CAL;
   wire logic int_cal = cal_on & ~mcode[1];
   wire logic soft_rst = pin_reset | ones_hit;

   // new mode value from a bus write, byte lanes 0 and 1
   wire logic [`ACRC_MODE_W-1:0] mode_new = {
      wb_sel_i[1] ? wb_dat_i[`ACRC_F_SKIP] : mode_q[`ACRC_F_SKIP], wb_dat_i[7:0]};
   wire logic [2:0] new_code = mode_new[`ACRC_F_MODE];
   wire logic wr_idle = mode_wr & (new_code == `ACRC_M_IDLE);
   wire logic wr_stby = mode_wr & (new_code == `ACRC_M_STBY);
   wire logic wr_run = mode_wr & ~wr_idle & ~wr_stby;
   wire logic wr_cal = wr_run & new_code[2];

   // words launched before the filter restart do not count
   wire logic word_ok = word_done & ~frst_q;
   // calibration end on the last counted output word
   wire logic cal_last = cal_on & word_ok &
      (wcnt_q == cal_words(mcode, mode_q[`ACRC_F_CHOP]) - 6'h01);
   wire logic conv_word = ~cal_on & word_done &
      (mcode == `ACRC_M_CONT || mcode == `ACRC_M_SINGLE);

   // events that set ready and settled flags
   wire logic flag_evt = soft_rst | rise_stby | pin_stby | rise_restart | mode_wr;
   wire logic data_rd = rd_take & hit_data;

   // ----------------------------------------
   // bus acknowledge and read data
   // ----------------------------------------
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (wb_adr_i == `ACRC_A_STATUS) begin
         rmux[`ACRC_S_READY] = ready_q;
         rmux[`ACRC_S_SETTLED] = settled_q;
         rmux[`ACRC_S_MODE] = mcode;
         rmux[`ACRC_S_PD] = pd_q;
      end else if (hit_mode) begin
         rmux[`ACRC_MODE_W-1:0] = mode_q;
      end else if (hit_data) begin
         rmux[23:0] = data_q;
      end else if (hit_ofs) begin
         rmux[23:0] = ofs_q[cal_idx];
      end else if (hit_gain) begin
         rmux[23:0] = gain_q[cal_idx];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         rdat_q <= req ? rmux : rdat_q;
      end
   end

   // ----------------------------------------
   // calibration sequencer
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ACRC_IDLE;
         wcnt_q <= 6'h00;
      end else if (soft_rst || pin_stby || rise_restart || mode_wr) begin
         state_q <= wr_cal && !soft_rst && !pin_stby ? ACRC_CAL : ACRC_IDLE;
         wcnt_q <= 6'h00;
      end else begin
         case (state_q)
            ACRC_IDLE: begin
               wcnt_q <= 6'h00;
            end
            ACRC_CAL: begin
               if (cal_last) begin
                  state_q <= ACRC_IDLE;
                  wcnt_q <= 6'h00;
               end else if (word_ok) begin
                  wcnt_q <= wcnt_q + 6'h01;
               end
            end
            default: begin
               state_q <= ACRC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // mode field and flags
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= `ACRC_MODE_RST;
         ready_q <= 1'b1;
         settled_q <= 1'b1;
         pd_q <= 1'b1;
      end else begin
         if (soft_rst) begin
            mode_q <= `ACRC_MODE_RST;
         end else if (mode_wr) begin
            mode_q <= mode_new;
         end else if (cal_last) begin
            mode_q[`ACRC_F_MODE] <= `ACRC_M_IDLE;
         end
         // analog power: down on standby, up when running
         if (rise_stby || pin_stby || wr_stby) begin
            pd_q <= 1'b1;
         end else if (wr_run && !soft_rst) begin
            pd_q <= 1'b0;
         end
         // flag set events win over clearing
         if (flag_evt) begin
            ready_q <= 1'b1;
            settled_q <= 1'b1;
         end else if (cal_last || conv_word) begin
            ready_q <= 1'b0;
            settled_q <= conv_word ? 1'b0 : settled_q;
         end else if (data_rd) begin
            ready_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // reset pulses, data word
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frst_q <= 1'b1;
         srst_q <= 1'b1;
         data_q <= 24'h000000;
      end else begin
         frst_q <= flag_evt;
         srst_q <= soft_rst;
         data_q <= conv_word ? filt_word : data_q;
      end
   end

   // ----------------------------------------
   // calibration coefficient registers
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            ofs_q[i] <= `ACRC_OFS_RST;
            gain_q[i] <= `ACRC_GAIN_RST;
         end
      end else if (soft_rst) begin
         for (int i = 0; i < NCH; i++) begin
            ofs_q[i] <= `ACRC_OFS_RST;
            gain_q[i] <= `ACRC_GAIN_RST;
         end
      end else if (cal_last) begin
         if (mcode[0]) begin
            gain_q[chan] <= cal_result;
         end else begin
            ofs_q[chan] <= cal_result;
         end
      end else if (wr_take && wb_sel_i[2:0] == 3'h7) begin
         if (hit_ofs) begin
            ofs_q[cal_idx] <= wb_dat_i[23:0];
         end else if (hit_gain) begin
            gain_q[cal_idx] <= wb_dat_i[23:0];
         end
      end
   end

   // ----------------------------------------
   // excitation divider and phase
   // ----------------------------------------
   logic [15:0] exc_cnt_q;
   logic phase_q;
   wire logic exc_tick = exc_cnt_q == 16'(EXC_DIV - 1);
   // internal calibrations force dc drive
   wire logic ac_on = mode_q[`ACRC_F_AC] & ~int_cal & ~pd_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         exc_cnt_q <= 16'h0000;
         phase_q <= 1'b0;
      end else begin
         exc_cnt_q <= exc_tick ? 16'h0000 : exc_cnt_q + 16'h0001;
         phase_q <= ac_on ? phase_q ^ exc_tick : 1'b0;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign rdy_pin = ready_q;
   assign filter_reset = frst_q;
   assign serial_reset = srst_q;
   assign analog_pd = pd_q;
   assign mode_out = mcode;
   assign fast_eff = mode_q[`ACRC_F_FAST] & ~cal_on;
   assign skip_eff = mode_q[`ACRC_F_SKIP] & ~cal_on;
   assign excite_ac = ac_on;
   assign bridge_drive_phase = phase_q;
   assign cal_input = !cal_on ? 2'h0 : mcode[1] ? 2'h0 : mcode[0] ? 2'h2 : 2'h1;
   assign ofs_out = ofs_q[chan];
   assign gain_out = gain_q[chan];

endmodule : acrc_ctrl
